// ---- hdl/rfap_bank.v ----
// Purpose: peripheral register bank applying common field access policies
// Assumes: single-word AHB-Lite transfers, one clock, async active-low reset
// Notes: zero wait states; read data registered at the address phase edge
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "rfap_consts.vh"

module rfap_bank (
	input wire clk_sys,
	input wire nrst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [15:0] hw_status,
	input wire [7:0] hw_event,
	input wire hw_count_inc,
	output wire [7:0] ctrl_out,
	output wire [7:0] set_out,
	output wire irq
);

	// ****************************************
	// address phase capture
	// ****************************************
	localparam [2:0] PH_IDLE = 3'h1;
	localparam [2:0] PH_WDATA = 3'h2;
	localparam [2:0] PH_RDATA = 3'h4;

	reg [2:0] phase_reg;
	reg [2:0] phase_next;
	reg [11:0] off_reg;
	reg [11:0] off_next;
	reg wr_pend;
	wire addr_valid;
	wire base_hit;
	wire addr_rd;
	wire addr_wr;
	wire [11:0] addr_off;

	assign base_hit = (haddr & `RFAP_BASE_MASK) == `RFAP_BASE_ADDR;
	assign addr_valid = hsel && hready && base_hit && hsize == `RFAP_HSIZE_WORD &&
		(htrans == `RFAP_HTRANS_NONSEQ || htrans == `RFAP_HTRANS_SEQ);
	assign addr_off = haddr[11:0] & `RFAP_OFF_MASK;
	assign addr_rd = addr_valid && !hwrite;
	assign addr_wr = addr_valid && hwrite;

	always @* begin
		phase_next = PH_IDLE;
		off_next = off_reg;
		case (phase_reg)
			PH_IDLE: begin
				if (addr_wr) begin
					phase_next = PH_WDATA;
				end else if (addr_rd) begin
					phase_next = PH_RDATA;
				end
			end
			PH_WDATA: begin
				if (addr_wr) begin
					phase_next = PH_WDATA;
				end else if (addr_rd) begin
					phase_next = PH_RDATA;
				end
			end
			PH_RDATA: begin
				if (addr_wr) begin
					phase_next = PH_WDATA;
				end else if (addr_rd) begin
					phase_next = PH_RDATA;
				end
			end
			default: begin
				phase_next = PH_IDLE;
			end
		endcase
		if (addr_valid) begin
			off_next = addr_off;
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase_reg <= PH_IDLE;
			off_reg <= 12'h000;
		end else begin
			phase_reg <= phase_next;
			off_reg <= off_next;
		end
	end

	always @* begin
		wr_pend = 1'b0;
		case (phase_reg)
			PH_IDLE: begin
				wr_pend = 1'b0;
			end
			PH_WDATA: begin
				wr_pend = 1'b1;
			end
			PH_RDATA: begin
				wr_pend = 1'b0;
			end
			default: begin
				wr_pend = 1'b0;
			end
		endcase
	end

	// ****************************************
	// register select
	// ****************************************
	wire [11:0] reg_off [0:`RFAP_NREG-1];
	wire [`RFAP_NREG-1:0] rd_sel;
	wire [`RFAP_NREG-1:0] wr_sel;

	assign reg_off[`RFAP_IDX_CTRL] = `RFAP_OFF_CTRL;
	assign reg_off[`RFAP_IDX_HWSTAT] = `RFAP_OFF_HWSTAT;
	assign reg_off[`RFAP_IDX_RCCNT] = `RFAP_OFF_RCCNT;
	assign reg_off[`RFAP_IDX_WCACC] = `RFAP_OFF_WCACC;
	assign reg_off[`RFAP_IDX_RIS] = `RFAP_OFF_RIS;
	assign reg_off[`RFAP_IDX_IMASK] = `RFAP_OFF_IMASK;
	assign reg_off[`RFAP_IDX_MIS] = `RFAP_OFF_MIS;
	assign reg_off[`RFAP_IDX_ICLR] = `RFAP_OFF_ICLR;
	assign reg_off[`RFAP_IDX_SETREG] = `RFAP_OFF_SETREG;

	genvar ri;
	generate
		for (ri = 0; ri < `RFAP_NREG; ri = ri + 1) begin : g_sel
			assign rd_sel[ri] = addr_rd && addr_off == reg_off[ri];
			assign wr_sel[ri] = wr_pend && off_reg == reg_off[ri];
		end
	endgenerate

	wire wr_ctrl = wr_sel[`RFAP_IDX_CTRL];
	wire rd_cnt = rd_sel[`RFAP_IDX_RCCNT];
	wire wr_wc = wr_sel[`RFAP_IDX_WCACC];
	wire wr_ris = wr_sel[`RFAP_IDX_RIS];
	wire wr_mask = wr_sel[`RFAP_IDX_IMASK];
	wire wr_iclr = wr_sel[`RFAP_IDX_ICLR];
	wire wr_set = wr_sel[`RFAP_IDX_SETREG];

	// ****************************************
	// read-write control
	// ****************************************
	reg [7:0] ctrl_reg;
	reg [7:0] ctrl_next;

	always @* begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next = hwdata[7:0];
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= `RFAP_CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end
	assign ctrl_out = ctrl_reg;

	// ****************************************
	// clear-on-read event counter
	// ****************************************
	reg [7:0] rccnt_reg;
	reg [7:0] rccnt_next;
	wire cnt_clr;
	wire cnt_inc;

	assign cnt_clr = rd_cnt;
	assign cnt_inc = hw_count_inc && ctrl_reg[`RFAP_CTRL_CNT_EN];

	always @* begin
		rccnt_next = rccnt_reg;
		if (cnt_clr) begin
			rccnt_next = `RFAP_ZERO8;
		end
		if (cnt_inc) begin
			rccnt_next = rccnt_next + `RFAP_ONE8;
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rccnt_reg <= `RFAP_ZERO8;
		end else begin
			rccnt_reg <= rccnt_next;
		end
	end

	// ****************************************
	// write-to-clear accumulator
	// ****************************************
	reg [15:0] wcacc_reg;
	reg [15:0] wcacc_next;

	always @* begin
		wcacc_next = wcacc_reg | hw_status;
		if (wr_wc) begin
			wcacc_next = hw_status;
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wcacc_reg <= `RFAP_ZERO16;
		end else begin
			wcacc_reg <= wcacc_next;
		end
	end

	// ****************************************
	// interrupt status, mask, set register
	// ****************************************
	reg [7:0] ris_reg;
	reg [7:0] mask_reg;
	reg [7:0] set_reg;
	reg [7:0] mask_next;
	wire [7:0] ris_next;
	wire [7:0] set_next;
	wire [7:0] clr_bits;
	wire [7:0] set_bits;
	wire [7:0] unset_bits;

	assign clr_bits = (wr_ris || wr_iclr) ? hwdata[7:0] : `RFAP_ZERO8;
	assign set_bits = wr_set ? hwdata[7:0] : `RFAP_ZERO8;
	assign unset_bits = wr_ctrl ? hwdata[`RFAP_UNSET_HI:`RFAP_UNSET_LO] : `RFAP_ZERO8;

	genvar gi;
	generate
		for (gi = 0; gi < `RFAP_EV_W; gi = gi + 1) begin : g_bit
			assign ris_next[gi] = hw_event[gi] || (ris_reg[gi] && !clr_bits[gi]);
			assign set_next[gi] = set_bits[gi] || (set_reg[gi] && !unset_bits[gi]);
		end
	endgenerate

	always @* begin
		mask_next = mask_reg;
		if (wr_mask) begin
			mask_next = hwdata[7:0];
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ris_reg <= `RFAP_ZERO8;
			mask_reg <= `RFAP_ZERO8;
			set_reg <= `RFAP_ZERO8;
		end else begin
			ris_reg <= ris_next;
			mask_reg <= mask_next;
			set_reg <= set_next;
		end
	end

	assign set_out = set_reg;
	assign irq = |(ris_reg & mask_reg);

	// ****************************************
	// read words, reserved bits tied to zero
	// ****************************************
	wire [31:0] rd_word [0:`RFAP_NREG-1];
	wire [31:0] rd_term [0:`RFAP_NREG-1];
	wire [31:0] rd_acc [0:`RFAP_NREG];
	wire [31:0] rdata_next;

	assign rd_word[`RFAP_IDX_CTRL] = {`RFAP_PAD24, ctrl_reg};
	assign rd_word[`RFAP_IDX_HWSTAT] = {`RFAP_ZERO16, hw_status};
	assign rd_word[`RFAP_IDX_RCCNT] = {`RFAP_PAD24, rccnt_reg};
	assign rd_word[`RFAP_IDX_WCACC] = {`RFAP_ZERO16, wcacc_reg};
	assign rd_word[`RFAP_IDX_RIS] = {`RFAP_PAD24, ris_reg};
	assign rd_word[`RFAP_IDX_IMASK] = {`RFAP_PAD24, mask_reg};
	assign rd_word[`RFAP_IDX_MIS] = {`RFAP_PAD24, ris_reg & mask_reg};
	assign rd_word[`RFAP_IDX_ICLR] = `RFAP_ZERO32;
	assign rd_word[`RFAP_IDX_SETREG] = {`RFAP_PAD24, set_reg};

	assign rd_acc[0] = `RFAP_ZERO32;

	genvar mi;
	generate
		for (mi = 0; mi < `RFAP_NREG; mi = mi + 1) begin : g_rd
			assign rd_term[mi] = rd_sel[mi] ? rd_word[mi] : `RFAP_ZERO32;
			assign rd_acc[mi + 1] = rd_acc[mi] | rd_term[mi];
		end
	endgenerate

	assign rdata_next = rd_acc[`RFAP_NREG];

	// ****************************************
	// read data register and response
	// ****************************************
	reg [31:0] rdata_reg;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= `RFAP_ZERO32;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	reg ready_comb;
	reg resp_comb;

	always @* begin
		ready_comb = 1'b1;
		resp_comb = `RFAP_HRESP_OKAY;
		case (phase_reg)
			PH_IDLE: begin
				ready_comb = 1'b1;
				resp_comb = `RFAP_HRESP_OKAY;
			end
			PH_WDATA: begin
				ready_comb = 1'b1;
				resp_comb = `RFAP_HRESP_OKAY;
			end
			PH_RDATA: begin
				ready_comb = 1'b1;
				resp_comb = `RFAP_HRESP_OKAY;
			end
			default: begin
				ready_comb = 1'b1;
				resp_comb = `RFAP_HRESP_OKAY;
			end
		endcase
	end

	assign hrdata = rdata_reg;
	assign hreadyout = ready_comb;
	assign hresp = resp_comb;

endmodule // rfap_bank

// ---- hdl/rfap_consts.vh ----
// Purpose: constants for the register field access policy bank
// Assumes: 32-bit AHB-Lite data, word-aligned registers
// Notes: offsets are byte offsets from the module base
`ifndef RFAP_CONSTS_VH
`define RFAP_CONSTS_VH

`define RFAP_BASE_ADDR 32'h4000_0000
`define RFAP_BASE_MASK 32'hffff_f000
`define RFAP_OFF_MASK 12'hffc

`define RFAP_OFF_CTRL 12'h000
`define RFAP_OFF_HWSTAT 12'h004
`define RFAP_OFF_RCCNT 12'h008
`define RFAP_OFF_WCACC 12'h00c
`define RFAP_OFF_RIS 12'h010
`define RFAP_OFF_IMASK 12'h014
`define RFAP_OFF_MIS 12'h018
`define RFAP_OFF_ICLR 12'h01c
`define RFAP_OFF_SETREG 12'h020

`define RFAP_NREG 9
`define RFAP_IDX_CTRL 0
`define RFAP_IDX_HWSTAT 1
`define RFAP_IDX_RCCNT 2
`define RFAP_IDX_WCACC 3
`define RFAP_IDX_RIS 4
`define RFAP_IDX_IMASK 5
`define RFAP_IDX_MIS 6
`define RFAP_IDX_ICLR 7
`define RFAP_IDX_SETREG 8

`define RFAP_PAD24 24'h00_0000
`define RFAP_CTRL_CNT_EN 0
`define RFAP_UNSET_HI 15
`define RFAP_UNSET_LO 8
`define RFAP_HSIZE_WORD 3'h2

`define RFAP_CTRL_W 8
`define RFAP_CTRL_RST 8'h00
`define RFAP_STAT_W 16
`define RFAP_EV_W 8
`define RFAP_ZERO32 32'h0000_0000
`define RFAP_ONE8 8'h01
`define RFAP_ZERO8 8'h00
`define RFAP_ZERO16 16'h0000

`define RFAP_HTRANS_NONSEQ 2'h2
`define RFAP_HTRANS_SEQ 2'h3
`define RFAP_HRESP_OKAY 1'h0

`endif

// ---- testbench/rfap_bank_props.sv ----
// Purpose: port checks of the field policy bank
// Assumes: zero wait states, idle cycle between transfers
// Notes: bound to rfap_bank
`timescale 1ns/1ps
`include "rfap_consts.vh"
module rfap_bank_chk (
	input wire clk_sys,
	input wire nrst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire [7:0] hw_event,
	input wire [7:0] ctrl_out,
	input wire [7:0] set_out,
	input wire irq
);
	localparam [31:0] B = `RFAP_BASE_ADDR;
	wire wr = hsel && htrans[1] && hwrite;
	wire rd = hsel && htrans[1] && !hwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready");
	chk_upper_zero: assert property (hrdata[31:16] == 16'h0000)
		else $error("upper bits set");
	chk_idle_zero: assert property (!$past(rd) |-> hrdata == 32'h0)
		else $error("data outside read");
	chk_ctrl_write: assert property ($past(wr && haddr == B, 2) |->
		ctrl_out == $past(hwdata[7:0])) else $error("ctrl wrong");
	chk_ctrl_keep: assert property (!$past(wr, 2) |-> $stable(ctrl_out))
		else $error("ctrl moved");
	chk_set_write: assert property ($past(wr && haddr == B + 32'h20, 2) |->
		set_out == ($past(set_out) | $past(hwdata[7:0]))) else $error("set wrong");
	chk_set_keep: assert property (!$past(wr, 2) |-> $stable(set_out))
		else $error("set moved");
	chk_irq_cause: assert property ($rose(irq) |-> $past(hw_event) != 8'h00 || $past(wr, 2))
		else $error("irq without cause");
endmodule // rfap_bank_chk
bind rfap_bank rfap_bank_chk rfap_bank_chk_inst (.*);

// ---- testbench/rfap_bank_tb_top.sv ----
// Purpose: directed bus test of the field policy bank
// Assumes: zero wait states
// Notes: offsets are byte offsets from the base
`timescale 1ns/1ps
`include "rfap_consts.vh"
module rfap_bank_tb_top;
	reg clk_sys = 0, nrst = 0, hsel = 0, hwrite = 0, hw_count_inc = 0;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0, hwdata = 32'h0;
	reg [15:0] hw_status = 16'h0;
	reg [7:0] hw_event = 8'h0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, irq;
	wire [7:0] ctrl_out, set_out;
	integer err_total = 0, num_checks = 0;
	always #25 clk_sys = ~clk_sys;
	rfap_bank rfap_bank_inst (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hw_status(hw_status),
		.hw_event(hw_event), .hw_count_inc(hw_count_inc), .ctrl_out(ctrl_out),
		.set_out(set_out), .irq(irq));
	task chk(input [39:0] n, input [31:0] g, input [31:0] e);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				$display("[FAIL] %s exp %h got %h", n, e, g);
				err_total = err_total + 1;
			end
		end
	endtask
	task t(input [11:0] o, input w, input [31:0] d);
		begin
			@(posedge clk_sys);
			hsel <= 1'h1;
			haddr <= `RFAP_BASE_ADDR + o;
			htrans <= 2'h2;
			hwrite <= w;
			@(posedge clk_sys);
			while (!hreadyout) @(posedge clk_sys);
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge clk_sys);
			while (!hreadyout) @(posedge clk_sys);
			if (!w) chk("rdata", hrdata, d);
			hsel <= 1'h0;
		end
	endtask
	task ev(input [7:0] e);
		begin
			hw_event <= e;
			@(posedge clk_sys);
			hw_event <= 8'h0;
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, err_total);
			if (err_total == 0 && num_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		#100000;
		err_total = err_total + 1;
		complete_run;
	end
	// ****
	// tests
	// ****
	initial begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'h1;
		hw_status <= 16'h0011;
		t(12'h000, 0, 32'h0);
		t(12'h000, 1, 32'hffff_ff01);
		hw_count_inc <= 1'h1;
		repeat (3) @(posedge clk_sys);
		hw_count_inc <= 1'h0;
		t(12'h000, 0, 32'h1);
		t(12'h000, 1, 32'h1);
		t(12'h000, 0, 32'h1);
		t(12'h008, 0, 32'h3);
		t(12'h008, 0, 32'h0);
		t(12'h004, 1, 32'h0);
		t(12'h004, 0, 32'h11);
		hw_status <= 16'h0100;
		t(12'h00c, 0, 32'h111);
		t(12'h00c, 1, 32'h0);
		hw_status <= 16'h0002;
		t(12'h00c, 0, 32'h102);
		$display("test counters done");
		ev(8'h0f);
		t(12'h010, 0, 32'h0f);
		chk("irq", irq, 32'h0);
		ev(8'h30);
		t(12'h010, 1, 32'h0f);
		t(12'h010, 0, 32'h30);
		t(12'h014, 1, 32'h30);
		t(12'h018, 0, 32'h30);
		chk("irq", irq, 32'h1);
		t(12'h01c, 1, 32'h10);
		t(12'h01c, 0, 32'h0);
		t(12'h010, 0, 32'h20);
		t(12'h014, 1, 32'h0);
		t(12'h040, 0, 32'h0);
		chk("irq", irq, 32'h0);
		$display("test interrupts done");
		t(12'h020, 1, 32'h81);
		t(12'h020, 1, 32'h02);
		t(12'h020, 1, 32'h0);
		t(12'h020, 0, 32'h83);
		t(12'h000, 1, 32'h101);
		t(12'h020, 0, 32'h82);
		chk("set", set_out, 32'h82);
		chk("ctrl", ctrl_out, 32'h1);
		$display("test set done");
		complete_run;
	end
endmodule // rfap_bank_tb_top
